// ==== hdl/ttc_top.sv ====
// three 16-bit up-counting timers with mode/control, count and limit registers
// assumes one 125 MHz core clock; timer pins arrive asynchronously
`timescale 1ns/1ps
`default_nettype none

// Function
// - software writes change enable only with guard bit written 1
// - guard bit not stored, reads zero
// - interrupt request on each limit match if enabled
// - pending request survives clearing the enable bit
// - status bit shows limit A or B
// - max-reached flag set on every limit match
// - restart edge resets count, else input gates
// - external clocking ignores restart, pin clocks count
// - chain bit advances on timer 2 match
// - outside-clock select counts from input pin
// - dual mode alternates limits A and B
// - one-shot mode clears enable at sequence end
// - one-shot dual mode runs A then B, halts
// - reset clears all mode/control registers
// - timer 2 single limit, reserved bits zero
// - internal clock advances every fourth cycle
// - limit zero counts full 16-bit range
// - limit register holds count maximum plus one
// - count and limit registers not reset
// - count resets to zero on match cycle
// - single mode wave pin low one cycle
// - dual mode wave pin shows active limit
// - output responds within eight clock cycles
module ttc_top #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [ttc_pkg::TTC_ADDR_W-1:0] reg_addr,
  input wire logic [ttc_pkg::TTC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ttc_pkg::TTC_DATA_W-1:0] reg_rdata,
  // timer pins
  input wire logic timer0_input_pin,
  input wire logic timer1_input_pin,
  output logic timer0_wave_pin,
  output logic timer1_wave_pin,
  // interrupt request lines toward the interrupt controller
  output logic [ttc_pkg::TTC_NUM-1:0] timer_irq,
  input wire logic [ttc_pkg::TTC_NUM-1:0] timer_irq_ack
);
  import ttc_pkg::*;

  generate
    if (CNT_W != TTC_DATA_W) begin : g_bad_width
      $error("ttc_top: CNT_W must equal the 16-bit register width");
    end
  endgenerate

  typedef struct packed {
    logic [1:0] div;
    logic [2:0][15:0] cnt;
    logic [2:0][15:0] lim_a;
    logic [2:0][15:0] lim_b;
    logic [2:0] en;
    logic [2:0] int_en;
    logic [2:0] acs;
    logic [2:0] mc;
    logic [2:0] restart;
    logic [2:0] chain;
    logic [2:0] outside_clock_select;
    logic [2:0] dual;
    logic [2:0] free_run;
    logic [2:0] irq;
    logic [1:0] wave;
    logic [1:0][2:0] sync;
    logic [1:0] lvl;
    logic [1:0] edge_pend;
    logic [15:0] rdata;
  } ttc_state_t;

  ttc_state_t q;
  ttc_state_t d;
  logic tick;
  logic t2hit;
  logic [2:0] hit;
  logic [1:0] rise;
  logic [1:0] pin_in;
  ttc_dec_t dec;

  function automatic ttc_dec_t ttc_decode(input logic [TTC_ADDR_W-1:0] a);
    ttc_dec_t r;
    r.ok = 1'b0;
    r.idx = 2'd0;
    r.kind = TTC_REG_CNT;
    for (int t = 0; t < TTC_NUM; t++) begin
      if (a == TTC_CNT_OFS[t]) begin
        r = '{ok: 1'b1, idx: 2'(t), kind: TTC_REG_CNT};
      end else if (a == TTC_LIM_A_OFS[t]) begin
        r = '{ok: 1'b1, idx: 2'(t), kind: TTC_REG_LIM_A};
      end else if (t < TTC_PIN_NUM && a == TTC_LIM_B_OFS[t[0]]) begin
        r = '{ok: 1'b1, idx: 2'(t), kind: TTC_REG_LIM_B};
      end else if (a == TTC_CTL_OFS[t]) begin
        r = '{ok: 1'b1, idx: 2'(t), kind: TTC_REG_CTL};
      end
    end
    return r;
  endfunction

  // guard bit and reserved bits always read zero; timer 2 has no pin fields
  function automatic logic [15:0] ttc_ctl_word(input ttc_state_t s, input int i);
    logic [15:0] w;
    w = '0;
    w[TTC_B_EN] = s.en[i];
    w[TTC_B_INT] = s.int_en[i];
    w[TTC_B_MC] = s.mc[i];
    w[TTC_B_FREE] = s.free_run[i];
    if (i < TTC_PIN_NUM) begin
      w[TTC_B_ACS] = s.acs[i];
      w[TTC_B_RESTART] = s.restart[i];
      w[TTC_B_CHAIN] = s.chain[i];
      w[TTC_B_EXT] = s.outside_clock_select[i];
      w[TTC_B_DUAL] = s.dual[i];
    end
    return w;
  endfunction

  assign pin_in = {timer1_input_pin, timer0_input_pin};
  assign dec = ttc_decode(reg_addr);
  assign tick = (q.div == TTC_DIV_LAST);

  always_comb begin
    logic has_pins;
    logic adv;
    logic clr;
    logic pend;
    logic [15:0] lim;
    logic [15:0] nxt;
    logic [15:0] rd_val;
    has_pins = 1'b0;
    adv = 1'b0;
    clr = 1'b0;
    pend = 1'b0;
    lim = '0;
    nxt = '0;
    rd_val = '0;
    d = q;
    hit = '0;
    t2hit = 1'b0;
    d.div = q.div + 2'd1;

    // three-stage synchroniser; level moves only when stages two and three agree
    // a pin held high through reset shows one edge after it; timers are idle then
    for (int p = 0; p < TTC_PIN_NUM; p++) begin
      d.sync[p] = {q.sync[p][1:0], pin_in[p]};
      if (q.sync[p][1] == q.sync[p][2]) begin
        d.lvl[p] = q.sync[p][2];
      end
      rise[p] = d.lvl[p] && !q.lvl[p];
    end

    // the interrupt controller's acknowledge is applied first so a new match wins
    for (int i = 0; i < TTC_NUM; i++) begin
      if (timer_irq_ack[i]) begin
        d.irq[i] = 1'b0;
      end
    end

    // timer 2 is serviced first so its match can prescale timers 0 and 1
    for (int i = TTC_NUM - 1; i >= 0; i--) begin
      has_pins = (i < TTC_PIN_NUM);
      pend = has_pins && q.edge_pend[i[0]];
      adv = 1'b0;
      clr = 1'b0;
      if (tick && has_pins) begin
        d.edge_pend[i[0]] = 1'b0;
      end
      if (tick && q.en[i]) begin
        if (has_pins && q.outside_clock_select[i]) begin
          adv = pend;
        end else begin
          adv = (has_pins && q.chain[i]) ? t2hit : 1'b1;
          if (has_pins && q.restart[i]) begin
            clr = pend;
          end else if (has_pins) begin
            adv = adv && q.lvl[i[0]];
          end
        end
      end
      lim = (has_pins && q.dual[i] && q.acs[i]) ? q.lim_b[i] : q.lim_a[i];
      // comparing the incremented value makes a zero limit wrap through ffff
      nxt = q.cnt[i] + TTC_CNT_STEP;
      if (clr) begin
        d.cnt[i] = '0;
      end else if (adv) begin
        if (nxt == lim) begin
          d.cnt[i] = '0;
          hit[i] = 1'b1;
          d.mc[i] = 1'b1;
          if (q.int_en[i]) begin
            d.irq[i] = 1'b1;
          end
          if (has_pins && q.dual[i]) begin
            d.acs[i] = !q.acs[i];
          end
          if (!q.free_run[i] && !(has_pins && q.dual[i] && !q.acs[i])) begin
            d.en[i] = 1'b0;
          end
        end else begin
          d.cnt[i] = nxt;
        end
      end
      if (i == TTC_NUM - 1) begin
        t2hit = hit[i];
      end
    end

    for (int p = 0; p < TTC_PIN_NUM; p++) begin
      if (rise[p]) begin
        d.edge_pend[p] = 1'b1;
      end
      // in dual mode high while limit A governs, low under limit B; otherwise low the cycle after a match
      d.wave[p] = q.dual[p] ? !d.acs[p] : !hit[p];
    end

    // software writes; count writes override the same-cycle increment
    if (reg_wr && dec.ok) begin
      case (dec.kind)
        TTC_REG_CNT: d.cnt[dec.idx] = reg_wdata;
        TTC_REG_LIM_A: d.lim_a[dec.idx] = reg_wdata;
        TTC_REG_LIM_B: d.lim_b[dec.idx] = reg_wdata;
        TTC_REG_CTL: begin
          if (reg_wdata[TTC_B_GUARD]) begin
            d.en[dec.idx] = reg_wdata[TTC_B_EN];
          end
          d.int_en[dec.idx] = reg_wdata[TTC_B_INT];
          d.free_run[dec.idx] = reg_wdata[TTC_B_FREE];
          // writing zero clears the flag; a match in the same cycle keeps it set
          if (!reg_wdata[TTC_B_MC] && !hit[dec.idx]) begin
            d.mc[dec.idx] = 1'b0;
          end
          if (dec.idx != 2'd2) begin
            d.restart[dec.idx] = reg_wdata[TTC_B_RESTART];
            d.chain[dec.idx] = reg_wdata[TTC_B_CHAIN];
            d.outside_clock_select[dec.idx] = reg_wdata[TTC_B_EXT];
            d.dual[dec.idx] = reg_wdata[TTC_B_DUAL];
            // a stale limit B selection must not show once dual mode is off
            if (!reg_wdata[TTC_B_DUAL]) begin
              d.acs[dec.idx] = 1'b0;
            end
          end
        end
        default: d.rdata = q.rdata;
      endcase
    end

    // read data stands only in the cycle after the read strobe
    if (reg_rd && dec.ok) begin
      case (dec.kind)
        TTC_REG_CNT: rd_val = q.cnt[dec.idx];
        TTC_REG_LIM_A: rd_val = q.lim_a[dec.idx];
        TTC_REG_LIM_B: rd_val = q.lim_b[dec.idx];
        TTC_REG_CTL: rd_val = ttc_ctl_word(q, int'(dec.idx));
        default: rd_val = '0;
      endcase
    end
    d.rdata = rd_val;

    // count and limit words are left alone by reset
    if (rst) begin
      d.div = '0;
      d.en = TTC_CTL_RESET[2:0];
      d.int_en = '0;
      d.acs = '0;
      d.mc = '0;
      d.restart = '0;
      d.chain = '0;
      d.outside_clock_select = '0;
      d.dual = '0;
      d.free_run = '0;
      d.irq = '0;
      d.wave = '1;
      d.sync = '0;
      d.lvl = '0;
      d.edge_pend = '0;
      d.rdata = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    q <= d;
  end

  assign reg_rdata = q.rdata;
  assign timer0_wave_pin = q.wave[0];
  assign timer1_wave_pin = q.wave[1];
  assign timer_irq = q.irq;

  default clocking ttc_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic is_ctl0_wr;
  logic is_ctl2_rd;
  assign is_ctl0_wr = reg_wr && dec.ok && dec.kind == TTC_REG_CTL && dec.idx == 2'd0;
  assign is_ctl2_rd = reg_rd && dec.ok && dec.kind == TTC_REG_CTL && dec.idx == 2'd2;

  guard_hold_a: assert property (
    is_ctl0_wr && !reg_wdata[TTC_B_GUARD] && !q.en[0] |=> !q.en[0])
    else $error("enable changed without guard bit");
  guard_read_a: assert property (
    reg_rd && dec.kind == TTC_REG_CTL |=> !reg_rdata[TTC_B_GUARD])
    else $error("guard bit read back as one");
  irq_on_hit_a: assert property (
    hit[0] && q.int_en[0] |=> timer_irq[0])
    else $error("match with interrupt enabled raised no request");
  irq_keep_a: assert property (
    timer_irq[1] && !timer_irq_ack[1] |=> timer_irq[1])
    else $error("request dropped without acknowledge");
  acs_flip_a: assert property (
    hit[0] && q.dual[0] |=> q.acs[0] != $past(q.acs[0]))
    else $error("active limit did not alternate");
  mc_set_a: assert property (
    hit[1] |=> q.mc[1])
    else $error("max-reached flag not set on match");
  oneshot_stop_a: assert property (
    hit[0] && !q.free_run[0] && !q.dual[0] && !reg_wr |=> !q.en[0])
    else $error("one-shot timer kept running");
  wave_pulse_a: assert property (
    hit[0] && !q.dual[0] && !reg_wr |=> !timer0_wave_pin ##1 timer0_wave_pin)
    else $error("wave pulse not exactly one cycle low");
  wrap_zero_a: assert property (
    hit[2] && !reg_wr |=> q.cnt[2] == 16'h0000)
    else $error("count not cleared on match");
  tick_only_a: assert property (
    q.cnt[2] != $past(q.cnt[2]) && !$past(reg_wr) && !$past(rst) |-> $past(tick))
    else $error("timer 2 advanced off a service cycle");
  t2_reserved_a: assert property (
    is_ctl2_rd |=> reg_rdata[12:6] == 7'h00 && reg_rdata[4:1] == 4'h0)
    else $error("timer 2 reserved bits not zero");
  // timers 0 and 1 stand for the shared engine in the checks below
  irq_quiet_a: assert property (
    hit[0] && !q.int_en[0] && !timer_irq[0] |=> !timer_irq[0])
    else $error("match with interrupt disabled raised a request");
  dual_halt_a: assert property (
    hit[0] && q.dual[0] && q.acs[0] && !q.free_run[0] && !reg_wr |=> !q.en[0])
    else $error("one-shot dual timer kept running after limit B");
  mc_hold_a: assert property (
    q.mc[0] && !is_ctl0_wr |=> q.mc[0])
    else $error("max-reached flag cleared without a write");
  gate_hold_a: assert property (
    tick && q.en[0] && !q.outside_clock_select[0] && !q.restart[0] && !q.lvl[0] && !reg_wr |=> $stable(q.cnt[0]))
    else $error("gated timer counted while its pin was low");
  restart_clr_a: assert property (
    tick && q.en[0] && !q.outside_clock_select[0] && q.restart[0] && q.edge_pend[0] && !reg_wr
      |=> q.cnt[0] == 16'h0000)
    else $error("restart edge did not clear the count");
  ext_step_a: assert property (
    tick && q.en[1] && q.outside_clock_select[1] && !q.edge_pend[1] && !reg_wr |=> $stable(q.cnt[1]))
    else $error("externally clocked timer moved without a pin edge");
  wave_dual_a: assert property (
    q.dual[0] && $past(q.dual[0]) |-> timer0_wave_pin == !q.acs[0])
    else $error("dual-mode wave pin does not follow the active limit");

  dual_cycle_c: cover property (hit[0] && q.dual[0] && q.acs[0]);
  chain_adv_c: cover property (tick && t2hit && q.chain[1] && q.en[1]);
  restart_c: cover property (tick && q.restart[0] && q.edge_pend[0] && q.en[0]);
  ext_edge_c: cover property (tick && q.outside_clock_select[1] && q.edge_pend[1] && q.en[1]);
  oneshot_end_c: cover property (hit[0] && !q.free_run[0] && !q.dual[0]);

endmodule

`default_nettype wire

// ==== hdl/ttc_pkg.sv ====
// constants, register map and decode types for the three-timer counter unit
// assumes a 16-bit register port addressed by byte offset
package ttc_pkg;

  localparam int TTC_ADDR_W = 8;
  localparam int TTC_DATA_W = 16;
  localparam int TTC_NUM = 3;
  localparam int TTC_PIN_NUM = 2;

  // register byte offsets, indexed by timer
  localparam logic [2:0][7:0] TTC_CNT_OFS = {8'h60, 8'h58, 8'h50};
  localparam logic [2:0][7:0] TTC_LIM_A_OFS = {8'h62, 8'h5a, 8'h52};
  localparam logic [1:0][7:0] TTC_LIM_B_OFS = {8'h5c, 8'h54};
  localparam logic [2:0][7:0] TTC_CTL_OFS = {8'h66, 8'h5e, 8'h56};

  // mode/control field positions
  localparam int TTC_B_EN = 15;
  localparam int TTC_B_GUARD = 14;
  localparam int TTC_B_INT = 13;
  localparam int TTC_B_ACS = 12;
  localparam int TTC_B_MC = 5;
  localparam int TTC_B_RESTART = 4;
  localparam int TTC_B_CHAIN = 3;
  localparam int TTC_B_EXT = 2;
  localparam int TTC_B_DUAL = 1;
  localparam int TTC_B_FREE = 0;

  localparam logic [15:0] TTC_CTL_RESET = 16'h0000;
  localparam logic [15:0] TTC_CNT_STEP = 16'h0001;

  // timers are serviced once every this many core clocks
  localparam int TTC_SERVICE_DIV = 4;
  localparam logic [1:0] TTC_DIV_LAST = 2'(TTC_SERVICE_DIV - 1);

  typedef enum logic [1:0] {
    TTC_REG_CNT,
    TTC_REG_LIM_A,
    TTC_REG_LIM_B,
    TTC_REG_CTL
  } ttc_reg_kind_t;

  typedef struct packed {
    logic ok;
    logic [1:0] idx;
    ttc_reg_kind_t kind;
  } ttc_dec_t;

endpackage

// ==== test/ttc_pin_src.sv ====
// model of the event sources that drive the two timer input pins
// assumes the bench asks for bursts one at a time and waits on busy
`timescale 1ns/1ps
`default_nettype none
module ttc_pin_src (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // burst request from the bench
  input wire logic start,
  input wire logic [1:0] sel,
  input wire logic [7:0] pulses,
  input wire logic [3:0] half_len,
  input wire logic [1:0] idle_lvl,
  // pins toward the timers
  output logic timer0_input_pin,
  output logic timer1_input_pin,
  output logic busy
);
  logic [8:0] phase_q;
  logic [3:0] hcnt_q;
  logic hi_q;
  // a longer half_len gives a slow source, the shortest one lasts a single core clock, less than a tick
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_q <= 9'h000;
      hcnt_q <= 4'h0;
      hi_q <= 1'b0;
    end else if (start && phase_q == 9'h000) begin
      phase_q <= {pulses, 1'b0};
      hcnt_q <= half_len;
      hi_q <= 1'b1;
    end else if (phase_q != 9'h000) begin
      if (hcnt_q == 4'h0) begin
        hcnt_q <= half_len;
        hi_q <= ~hi_q;
        phase_q <= phase_q - 9'h001;
      end else begin
        hcnt_q <= hcnt_q - 4'h1;
      end
    end
  end
  assign busy = phase_q != 9'h000;
  // outside a burst each pin sits at the level the bench holds
  assign timer0_input_pin = (busy && sel[0]) ? hi_q : idle_lvl[0];
  assign timer1_input_pin = (busy && sel[1]) ? hi_q : idle_lvl[1];
endmodule
`default_nettype wire

// ==== test/tb_three_timer_counter_unit.sv ====
// self-checking bench for the three-timer counter unit
// assumes the pin source model and the register port of ttc_top
`timescale 1ns/1ps
`default_nettype none
module tb_three_timer_counter_unit;
  import ttc_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, start = 1'b0;
  logic [7:0] reg_addr = 8'h00, pulses = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, v;
  logic [1:0] sel = 2'h0, idle = 2'h3;
  logic [3:0] half = 4'h4;
  logic [2:0] irq, ack = 3'h0;
  logic p0, p1, w0, w1, busy;
  int fail_count = 0, samples_checked = 0, lows;
  always #4 core_clk = ~core_clk;
  ttc_top dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer0_input_pin(p0),
    .timer1_input_pin(p1), .timer0_wave_pin(w0), .timer1_wave_pin(w1), .timer_irq(irq),
    .timer_irq_ack(ack));
  ttc_pin_src src (.core_clk(core_clk), .rst(rst), .start(start), .sel(sel), .pulses(pulses),
    .half_len(half), .idle_lvl(idle), .timer0_input_pin(p0), .timer1_input_pin(p1), .busy(busy));
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chkr(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    samples_checked++;
    if (!(got >= lo && got <= hi)) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    chkr(v, e, e);
  endtask
  task automatic ackp(input logic [2:0] m);
    @(posedge core_clk);
    ack <= m;
    @(posedge core_clk);
    ack <= 3'h0;
    @(posedge core_clk);
    #1 chkr(16'(irq), 16'h0000, 16'h0000);
  endtask
  task automatic burst(input logic [1:0] s, input logic [7:0] n, input logic [3:0] h);
    @(posedge core_clk);
    sel <= s;
    pulses <= n;
    half <= h;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (2) @(posedge core_clk);
    repeat (400) if (busy) @(posedge core_clk);
    repeat (12) @(posedge core_clk);
  endtask
  task automatic watch_low(input int n);
    lows = 0;
    repeat (n) begin
      @(posedge core_clk);
      #1 lows += (w0 === 1'b0 || w1 === 1'b0) ? 1 : 0;
    end
  endtask
  task automatic t_reset;
    rdc(8'h56, 16'h0000);
    rdc(8'h5e, 16'h0000);
    rdc(8'h66, 16'h0000);
    chkr({13'h0000, irq}, 16'h0000, 16'h0000);
    wr(8'h62, 16'h0007);
    wr(8'h64, 16'h1234);
    rdc(8'h64, 16'h0000);
    rdc(8'h62, 16'h0007);
  endtask
  task automatic t_guard;
    wr(8'h50, 16'h0000);
    wr(8'h52, 16'hffff);
    wr(8'h56, 16'h8000);
    rdc(8'h56, 16'h0000);
    wr(8'h56, 16'hc000);
    rdc(8'h56, 16'h8000);
    wr(8'h56, 16'h0001);
    rdc(8'h56, 16'h8001);
    wr(8'h56, 16'h4000);
    rdc(8'h56, 16'h0000);
  endtask
  task automatic t_single;
    wr(8'h58, 16'h0000);
    wr(8'h5a, 16'h0002);
    wr(8'h5e, 16'he000);
    watch_low(30);
    chkr(16'(lows), 16'h0001, 16'h0001);
    chkr(16'(irq), 16'h0002, 16'h0002);
    rdc(8'h5e, 16'h2020);
    rdc(8'h58, 16'h0000);
    ackp(3'h2);
    wr(8'h5e, 16'h2020);
    rdc(8'h5e, 16'h2020);
    wr(8'h5e, 16'h2000);
    rdc(8'h5e, 16'h2000);
  endtask
  task automatic t_timer2;
    wr(8'h60, 16'h0000);
    wr(8'h62, 16'h0002);
    wr(8'h66, 16'hffdf);
    rdc(8'h66, 16'ha001);
    repeat (40) if (irq[2] !== 1'b1) @(posedge core_clk);
    wr(8'h66, 16'h4000);
    repeat (3) @(posedge core_clk);
    #1 chkr(16'(irq), 16'h0004, 16'h0004);
    ackp(3'h4);
  endtask
  task automatic t_dual;
    wr(8'h50, 16'h0000);
    wr(8'h52, 16'h0001);
    wr(8'h54, 16'h0003);
    wr(8'h56, 16'hc002);
    repeat (6) @(posedge core_clk);
    rdc(8'h56, 16'h9022);
    repeat (30) @(posedge core_clk);
    wr(8'h50, 16'h0000);
    wr(8'h56, 16'hc002);
    watch_low(40);
    chkr(16'(lows), 16'h000c, 16'h000c);
    rdc(8'h56, 16'h0022);
  endtask
  task automatic t_gate;
    idle <= 2'h2;
    wr(8'h50, 16'h0005);
    wr(8'h52, 16'hffff);
    wr(8'h56, 16'hc001);
    repeat (40) @(posedge core_clk);
    rdc(8'h50, 16'h0005);
    idle <= 2'h3;
    repeat (12) @(posedge core_clk);
    wr(8'h50, 16'h0000);
    repeat (40) @(posedge core_clk);
    rd(8'h50);
    chkr(v, 16'h0009, 16'h000b);
    wr(8'h56, 16'hc011);
    idle <= 2'h2;
    repeat (60) @(posedge core_clk);
    burst(2'h1, 8'h01, 4'h6);
    rd(8'h50);
    chkr(v, 16'h0000, 16'h0008);
    wr(8'h56, 16'h4000);
  endtask
  task automatic t_ext;
    idle <= 2'h0;
    wr(8'h58, 16'h0000);
    wr(8'h5a, 16'hffff);
    wr(8'h5e, 16'hc015);
    burst(2'h2, 8'h05, 4'h4);
    rdc(8'h58, 16'h0005);
    wr(8'h5e, 16'h4000);
  endtask
  task automatic t_chain;
    idle <= 2'h3;
    wr(8'h60, 16'h0000);
    wr(8'h62, 16'h0004);
    wr(8'h66, 16'hc001);
    wr(8'h50, 16'h0000);
    wr(8'h56, 16'hc009);
    repeat (160) @(posedge core_clk);
    wr(8'h56, 16'h4000);
    rd(8'h50);
    chkr(v, 16'h0009, 16'h000b);
    wr(8'h66, 16'h4000);
  endtask
  task automatic t_zero;
    wr(8'h50, 16'hfffe);
    wr(8'h52, 16'h0000);
    wr(8'h56, 16'he000);
    repeat (30) @(posedge core_clk);
    #1 chkr(16'(irq), 16'h0001, 16'h0001);
    rdc(8'h56, 16'h2020);
    rdc(8'h50, 16'h0000);
    ackp(3'h1);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_guard();
    t_single();
    t_timer2();
    t_dual();
    t_gate();
    t_ext();
    t_chain();
    t_zero();
    results();
  end
  // the whole sequence needs about seven hundred cycles
  initial begin
    repeat (6000) @(posedge core_clk);
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
